// *** core/fwc_pkg.sv ***
/*
 * Constants, register map and state encodings for the flash write/erase controller.
 * Assumes a single system bus clock and a bus master that writes whole words.
 */
// Summary of operation
// - Configuration bit 20 reads 1 while a program or page erase runs.
// - Configuration bit 19 reads 1 while the one-entry write buffer is full.
// - Bit 18 clear programs a half-word; set erases the page holding the address.
// - Bit 16 with multiple unlock marks programming accesses as sequential, faster.
// - Bit 7 set inhibits prefetch; clear lets prefetch fill its buffer.
// - Bit 6 set lets data accesses use the prefetch buffer.
// - Bit 4 set stores the first flash access before returning it.
// - Bits 1:0 pick one of four speed modes; software matches bus clock.
// - Configuration also answers at +0x4 setting ones and +0x8 clearing ones.
// - A 32-bit read/write target address selects the location or page.
// - Programming writes the low 16 data bits; upper 16 bits are dropped.
// - Key 0xA5 then 0xF1 unlocks one operation, then relocks itself.
// - Key 0xA5 then 0xF2 unlocks until software writes lock key 0x5A.
// - Timing control bit 6 selects read timing below or above 12 MHz.
// - Each accepted data write advances the target address by two.
// - Data write while locked or bad key sequence locks until reset.
// - Data write with the buffer full stalls the bus until room frees.
// - Program and erase requests are ignored while the supply qualifier is low.
package fwc_pkg;
	localparam logic [31:0] CFG_ADDR = 32'h4002E000;
	localparam logic [31:0] SET_OFS = 32'h00000004;
	localparam logic [31:0] CLR_OFS = 32'h00000008;
	localparam logic [31:0] TADDR_ADDR = 32'h4002E0A0;
	localparam logic [31:0] DATA_ADDR = 32'h4002E0B0;
	localparam logic [31:0] KEY_ADDR = 32'h4002E0C0;
	localparam logic [31:0] TCTL_ADDR = 32'h4002E0D0;
	localparam int BUSY_BIT = 20;
	localparam int BUF_BIT = 19;
	localparam int ERASE_BIT = 18;
	localparam int SQW_BIT = 16;
	localparam int PREFETCH_INHIBIT_BIT = 7;
	localparam int DPF_BIT = 6;
	localparam int RDS_BIT = 4;
	localparam int SPD_MSB = 1;
	localparam int SPD_LSB = 0;
	localparam int RTM_BIT = 6;
	localparam logic [31:0] CFG_RESET = 32'h00000720;
	localparam logic [31:0] CFG_WMASK = 32'h000707F3;
	localparam logic [31:0] TCTL_RESET = 32'h0003005C;
	localparam logic [31:0] TCTL_WMASK = 32'h0003007F;
	localparam logic [31:0] TADDR_RESET = 32'h00000000;
	localparam logic [7:0] KEY_RESET = 8'h00;
	localparam logic [31:0] ADDR_STEP = 32'h00000002;
	localparam logic [7:0] KEY_INITIAL = 8'hA5;
	localparam logic [7:0] KEY_SINGLE_UNLOCK = 8'hF1;
	localparam logic [7:0] KEY_MULTI_UNLOCK = 8'hF2;
	localparam logic [7:0] KEY_MULTI_LOCK = 8'h5A;
	typedef enum logic [2:0] {
		KS_LOCKED = 3'b000,
		KS_INIT = 3'b001,
		KS_SINGLE = 3'b010,
		KS_MULTI = 3'b011,
		KS_DEAD = 3'b100
	} fwc_key_state_type;
	typedef enum logic {
		ENG_IDLE = 1'b0,
		ENG_RUN = 1'b1
	} fwc_eng_state_type;
endpackage

// *** core/fwc_level_sync.sv ***
/*
 * Three-stage synchroniser for a slow level from outside the clock domain.
 * The output only follows once stages two and three agree, filtering glitches.
 */
`timescale 1ns/1ps
module fwc_level_sync (
	input wire logic clock, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic din, // asynchronous level
	output logic dout // filtered, synchronised level
);
	logic s1_r, s2_r, s3_r, out_r;
	logic out_nxt;

	always_comb begin
		out_nxt = out_r;
		if (s2_r == s3_r) begin
			out_nxt = s3_r;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			out_r <= 1'b0;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
			out_r <= out_nxt;
		end
	end

	assign dout = out_r;
endmodule // fwc_level_sync

// *** core/fwc_flash_ctrl.sv ***
/*
 * Flash write/erase controller: bus slave registers, key unlock machine,
 * one-entry write buffer and operation engine towards the flash array.
 * Assumes the bus hready input reflects this slave's hreadyout while selected,
 * and a flash array that pulses fl_ack once per finished operation.
 */
`timescale 1ns/1ps
module fwc_flash_ctrl (
	input wire logic clock, // system bus clock
	input wire logic rst_n, // async reset, active low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // bus address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write strobe
	input wire logic hready, // bus ready in
	input wire logic [31:0] hwdata, // write data
	output logic [31:0] hrdata, // read data
	output logic hreadyout, // low stalls the bus
	output logic hresp, // always OKAY
	input wire logic mon_enabled, // supply monitor enabled as reset source
	output logic fl_req, // operation request, held until ack
	output logic fl_erase, // 1 page erase, 0 program
	output logic fl_seq, // sequential programming hint
	output logic [31:0] fl_addr, // target address
	output logic [15:0] fl_data, // half-word to program
	input wire logic fl_ack, // operation done pulse
	output logic prefetch_inhibit, // prefetch engine off
	output logic data_prefetch_enable, // data accesses use prefetch
	output logic read_store_enable, // first access stored
	output logic [1:0] speed_mode_select, // flash speed mode
	output logic read_timing_mode // read timing for fast bus
);
	function automatic logic hit(input logic [31:0] a, input logic [31:0] t);
		return a == t;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
			input logic [31:0] mask);
		return (old & ~mask) | (nv & mask);
	endfunction

	logic mon_ok;
	fwc_level_sync u_mon_sync (
		.clock(clock),
		.rst_n(rst_n),
		.din(mon_enabled),
		.dout(mon_ok)
	);

	// Bus pipeline and registers
	logic ap_valid_r, ap_valid_nxt, ap_write_r, ap_write_nxt;
	logic [31:0] ap_addr_r, ap_addr_nxt;
	logic hreadyout_r, hreadyout_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;
	logic [31:0] cfg_r, cfg_nxt, tctl_r, tctl_nxt, taddr_r, taddr_nxt;
	logic [7:0] key_last_r, key_last_nxt;
	fwc_pkg::fwc_key_state_type key_r, key_nxt;
	// Engine and buffer
	fwc_pkg::fwc_eng_state_type eng_r, eng_nxt;
	logic fl_req_r, fl_req_nxt, fl_erase_r, fl_erase_nxt, fl_seq_r, fl_seq_nxt;
	logic [31:0] fl_addr_r, fl_addr_nxt, buf_addr_r, buf_addr_nxt;
	logic [15:0] fl_data_r, fl_data_nxt, buf_data_r, buf_data_nxt;
	logic buf_valid_r, buf_valid_nxt, buf_erase_r, buf_erase_nxt;
	logic buf_seq_r, buf_seq_nxt;

	logic accept, dp_wr, wr_cfg, wr_set, wr_clr, wr_taddr, wr_data, wr_key, wr_tctl;
	logic unlocked, op_take, op_violate, busy_now, seq_cond, op_direct;
	logic [31:0] status_word, set_bits;

	assign accept = hsel & htrans[1] & hready;
	assign dp_wr = ap_valid_r & ap_write_r & hreadyout_r;
	assign wr_cfg = dp_wr & hit(ap_addr_r, fwc_pkg::CFG_ADDR);
	assign wr_set = dp_wr & hit(ap_addr_r, fwc_pkg::CFG_ADDR + fwc_pkg::SET_OFS);
	assign wr_clr = dp_wr & hit(ap_addr_r, fwc_pkg::CFG_ADDR + fwc_pkg::CLR_OFS);
	assign wr_taddr = dp_wr & hit(ap_addr_r, fwc_pkg::TADDR_ADDR);
	assign wr_data = dp_wr & hit(ap_addr_r, fwc_pkg::DATA_ADDR);
	assign wr_key = dp_wr & hit(ap_addr_r, fwc_pkg::KEY_ADDR);
	assign wr_tctl = dp_wr & hit(ap_addr_r, fwc_pkg::TCTL_ADDR);
	assign unlocked = (key_r == fwc_pkg::KS_SINGLE) || (key_r == fwc_pkg::KS_MULTI);
	// Supply qualifier low: request ignored, not treated as a violation
	assign op_take = wr_data & mon_ok & unlocked;
	assign op_violate = wr_data & mon_ok & !unlocked;
	assign busy_now = (eng_r == fwc_pkg::ENG_RUN) | buf_valid_r;
	assign seq_cond = cfg_r[fwc_pkg::SQW_BIT] & (key_r == fwc_pkg::KS_MULTI);
	// Engine free this cycle: idle, or its running op finishes now with nothing queued
	assign op_direct = op_take & !buf_valid_r & ((eng_r == fwc_pkg::ENG_IDLE) | fl_ack);
	assign set_bits = hwdata & fwc_pkg::CFG_WMASK;

	always_comb begin
		status_word = cfg_r;
		status_word[fwc_pkg::BUSY_BIT] = busy_now;
		status_word[fwc_pkg::BUF_BIT] = buf_valid_r;
	end

	// Register file and key machine
	always_comb begin
		cfg_nxt = cfg_r;
		tctl_nxt = tctl_r;
		taddr_nxt = taddr_r;
		key_last_nxt = key_last_r;
		key_nxt = key_r;
		if (wr_cfg) begin
			cfg_nxt = merge(cfg_r, hwdata, fwc_pkg::CFG_WMASK);
		end else if (wr_set) begin
			cfg_nxt = cfg_r | set_bits;
		end else if (wr_clr) begin
			cfg_nxt = cfg_r & ~set_bits;
		end
		if (wr_tctl) begin
			tctl_nxt = merge(tctl_r, hwdata, fwc_pkg::TCTL_WMASK);
		end
		if (wr_taddr) begin
			taddr_nxt = hwdata;
		end else if (op_take) begin
			taddr_nxt = taddr_r + fwc_pkg::ADDR_STEP;
		end
		if (wr_key) begin
			key_last_nxt = hwdata[7:0];
		end
		case (key_r)
			fwc_pkg::KS_LOCKED: begin
				if (wr_key) begin
					key_nxt = (hwdata[7:0] == fwc_pkg::KEY_INITIAL) ?
						fwc_pkg::KS_INIT : fwc_pkg::KS_DEAD;
				end else if (op_violate) begin
					key_nxt = fwc_pkg::KS_DEAD;
				end
			end
			fwc_pkg::KS_INIT: begin
				if (wr_key && hwdata[7:0] == fwc_pkg::KEY_SINGLE_UNLOCK) begin
					key_nxt = fwc_pkg::KS_SINGLE;
				end else if (wr_key && hwdata[7:0] == fwc_pkg::KEY_MULTI_UNLOCK) begin
					key_nxt = fwc_pkg::KS_MULTI;
				end else if (wr_key || op_violate) begin
					key_nxt = fwc_pkg::KS_DEAD;
				end
			end
			fwc_pkg::KS_SINGLE: begin
				// Relocks once the single operation is taken; other keys keep it open
				if (op_take) begin
					key_nxt = fwc_pkg::KS_LOCKED;
				end
			end
			fwc_pkg::KS_MULTI: begin
				if (wr_key && hwdata[7:0] == fwc_pkg::KEY_MULTI_LOCK) begin
					key_nxt = fwc_pkg::KS_LOCKED;
				end
			end
			default: begin
				key_nxt = fwc_pkg::KS_DEAD;
			end
		endcase
	end

	// Operation engine and write buffer
	always_comb begin
		eng_nxt = eng_r;
		fl_req_nxt = fl_req_r;
		fl_erase_nxt = fl_erase_r;
		fl_seq_nxt = fl_seq_r;
		fl_addr_nxt = fl_addr_r;
		fl_data_nxt = fl_data_r;
		buf_valid_nxt = buf_valid_r;
		buf_addr_nxt = buf_addr_r;
		buf_data_nxt = buf_data_r;
		buf_erase_nxt = buf_erase_r;
		buf_seq_nxt = buf_seq_r;
		case (eng_r)
			fwc_pkg::ENG_RUN: begin
				if (fl_ack) begin
					fl_req_nxt = 1'b0;
					eng_nxt = fwc_pkg::ENG_IDLE;
					if (buf_valid_r) begin
						eng_nxt = fwc_pkg::ENG_RUN;
						fl_req_nxt = 1'b1;
						fl_addr_nxt = buf_addr_r;
						fl_data_nxt = buf_data_r;
						fl_erase_nxt = buf_erase_r;
						fl_seq_nxt = buf_seq_r;
						buf_valid_nxt = 1'b0;
					end
				end
			end
			default: begin
				if (buf_valid_r) begin
					eng_nxt = fwc_pkg::ENG_RUN;
					fl_req_nxt = 1'b1;
					fl_addr_nxt = buf_addr_r;
					fl_data_nxt = buf_data_r;
					fl_erase_nxt = buf_erase_r;
					fl_seq_nxt = buf_seq_r;
					buf_valid_nxt = 1'b0;
				end
			end
		endcase
		if (op_take) begin
			if (eng_nxt == fwc_pkg::ENG_IDLE && !buf_valid_r) begin
				eng_nxt = fwc_pkg::ENG_RUN;
				fl_req_nxt = 1'b1;
				fl_addr_nxt = taddr_r;
				fl_data_nxt = hwdata[15:0];
				fl_erase_nxt = cfg_r[fwc_pkg::ERASE_BIT];
				fl_seq_nxt = seq_cond;
			end else begin
				// Room is guaranteed: the stall below held the transfer until now
				buf_valid_nxt = 1'b1;
				buf_addr_nxt = taddr_r;
				buf_data_nxt = hwdata[15:0];
				buf_erase_nxt = cfg_r[fwc_pkg::ERASE_BIT];
				buf_seq_nxt = seq_cond;
			end
		end
	end

	// Bus pipeline, stall and read data
	always_comb begin
		ap_valid_nxt = ap_valid_r;
		ap_write_nxt = ap_write_r;
		ap_addr_nxt = ap_addr_r;
		hreadyout_nxt = 1'b1;
		hrdata_nxt = hrdata_r;
		if (ap_valid_r && !hreadyout_r) begin
			hreadyout_nxt = !buf_valid_nxt;
		end else if (hready) begin
			ap_valid_nxt = accept;
			ap_write_nxt = hwrite;
			ap_addr_nxt = haddr;
			if (accept && hwrite && hit(haddr, fwc_pkg::DATA_ADDR)) begin
				hreadyout_nxt = !buf_valid_nxt;
			end
			if (accept && !hwrite) begin
				if (hit(haddr, fwc_pkg::CFG_ADDR) ||
						hit(haddr, fwc_pkg::CFG_ADDR + fwc_pkg::SET_OFS) ||
						hit(haddr, fwc_pkg::CFG_ADDR + fwc_pkg::CLR_OFS)) begin
					hrdata_nxt = status_word;
				end else if (hit(haddr, fwc_pkg::TADDR_ADDR)) begin
					hrdata_nxt = taddr_r;
				end else if (hit(haddr, fwc_pkg::KEY_ADDR)) begin
					hrdata_nxt = {24'h000000, key_last_r};
				end else if (hit(haddr, fwc_pkg::TCTL_ADDR)) begin
					hrdata_nxt = tctl_r;
				end else begin
					hrdata_nxt = 32'h00000000;
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ap_valid_r <= 1'b0;
			ap_write_r <= 1'b0;
			ap_addr_r <= 32'h00000000;
			hreadyout_r <= 1'b1;
			hrdata_r <= 32'h00000000;
			cfg_r <= fwc_pkg::CFG_RESET;
			tctl_r <= fwc_pkg::TCTL_RESET;
			taddr_r <= fwc_pkg::TADDR_RESET;
			key_last_r <= fwc_pkg::KEY_RESET;
			key_r <= fwc_pkg::KS_LOCKED;
			eng_r <= fwc_pkg::ENG_IDLE;
			fl_req_r <= 1'b0;
			fl_erase_r <= 1'b0;
			fl_seq_r <= 1'b0;
			fl_addr_r <= 32'h00000000;
			fl_data_r <= 16'h0000;
			buf_valid_r <= 1'b0;
			buf_addr_r <= 32'h00000000;
			buf_data_r <= 16'h0000;
			buf_erase_r <= 1'b0;
			buf_seq_r <= 1'b0;
		end else begin
			ap_valid_r <= ap_valid_nxt;
			ap_write_r <= ap_write_nxt;
			ap_addr_r <= ap_addr_nxt;
			hreadyout_r <= hreadyout_nxt;
			hrdata_r <= hrdata_nxt;
			cfg_r <= cfg_nxt;
			tctl_r <= tctl_nxt;
			taddr_r <= taddr_nxt;
			key_last_r <= key_last_nxt;
			key_r <= key_nxt;
			eng_r <= eng_nxt;
			fl_req_r <= fl_req_nxt;
			fl_erase_r <= fl_erase_nxt;
			fl_seq_r <= fl_seq_nxt;
			fl_addr_r <= fl_addr_nxt;
			fl_data_r <= fl_data_nxt;
			buf_valid_r <= buf_valid_nxt;
			buf_addr_r <= buf_addr_nxt;
			buf_data_r <= buf_data_nxt;
			buf_erase_r <= buf_erase_nxt;
			buf_seq_r <= buf_seq_nxt;
		end
	end

	assign hrdata = hrdata_r;
	assign hreadyout = hreadyout_r;
	assign hresp = 1'b0;
	assign fl_req = fl_req_r;
	assign fl_erase = fl_erase_r;
	assign fl_seq = fl_seq_r;
	assign fl_addr = fl_addr_r;
	assign fl_data = fl_data_r;
	// Read-path options go straight from the configuration and timing control flops to the read side
	assign prefetch_inhibit = cfg_r[fwc_pkg::PREFETCH_INHIBIT_BIT];
	assign data_prefetch_enable = cfg_r[fwc_pkg::DPF_BIT];
	assign read_store_enable = cfg_r[fwc_pkg::RDS_BIT];
	assign speed_mode_select = cfg_r[fwc_pkg::SPD_MSB:fwc_pkg::SPD_LSB];
	assign read_timing_mode = tctl_r[fwc_pkg::RTM_BIT];

	logic rd_cfg;
	assign rd_cfg = accept & !hwrite & hready & hit(haddr, fwc_pkg::CFG_ADDR) &
		!(ap_valid_r & !hreadyout_r);

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_dead_held;
		(key_r == fwc_pkg::KS_DEAD) [*3];
	endsequence

	sequence s_req_started;
		fl_req && fl_erase == $past(cfg_r[fwc_pkg::ERASE_BIT]) &&
			fl_addr == $past(taddr_r) && fl_data == $past(hwdata[15:0]);
	endsequence

	property p_busy_flag;
		rd_cfg |=> hrdata[fwc_pkg::BUSY_BIT] == $past(busy_now);
	endproperty
	a_busy_flag: assert property (p_busy_flag) else $error("busy flag wrong");

	property p_buf_flag;
		rd_cfg |=> hrdata[fwc_pkg::BUF_BIT] == $past(buf_valid_r);
	endproperty
	a_buf_flag: assert property (p_buf_flag) else $error("buffer flag wrong");

	property p_direct_op;
		op_direct |=> s_req_started;
	endproperty
	a_direct_op: assert property (p_direct_op) else $error("direct op wrong");

	property p_seq_hint;
		op_direct |=> fl_seq == $past(seq_cond);
	endproperty
	a_seq_hint: assert property (p_seq_hint) else $error("seq hint wrong");

	property p_set_alias;
		wr_set |=> (cfg_r & $past(set_bits)) == $past(set_bits);
	endproperty
	a_set_alias: assert property (p_set_alias) else $error("set alias failed");

	property p_addr_step;
		op_take && !wr_taddr |=> taddr_r == $past(taddr_r) + fwc_pkg::ADDR_STEP;
	endproperty
	a_addr_step: assert property (p_addr_step) else $error("address step wrong");

	property p_single_relock;
		op_take && key_r == fwc_pkg::KS_SINGLE |=> key_r == fwc_pkg::KS_LOCKED;
	endproperty
	a_single_relock: assert property (p_single_relock) else $error("no relock");

	property p_multi_hold;
		key_r == fwc_pkg::KS_MULTI && !wr_key |=> key_r == fwc_pkg::KS_MULTI;
	endproperty
	a_multi_hold: assert property (p_multi_hold) else $error("multi lost");

	property p_violation;
		op_violate |=> s_dead_held;
	endproperty
	a_violation: assert property (p_violation) else $error("lock not permanent");

	property p_stall;
		!hreadyout |-> buf_valid_r && ap_valid_r;
	endproperty
	a_stall: assert property (p_stall) else $error("stall without full buffer");

	property p_mon_ignore;
		wr_data && !mon_ok |=> $stable(key_r) && $stable(taddr_r);
	endproperty
	a_mon_ignore: assert property (p_mon_ignore) else $error("op not ignored");

	property p_req_hold;
		fl_req && !fl_ack |=> fl_req;
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request dropped");
endmodule // fwc_flash_ctrl

// *** bench/fwc_flash_model.sv ***
/*
 * Behavioural flash array for the write/erase controller bench.
 * Assumes the controller holds fl_req and its fields until fl_ack is seen.
 */
`timescale 1ns/1ps
module fwc_flash_model (
	input wire logic clock, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic fl_req, // operation request
	input wire logic fl_erase, // page erase when high
	input wire logic fl_seq, // sequential hint
	input wire logic [31:0] fl_addr, // target address
	input wire logic [15:0] fl_data, // half-word to program
	input wire logic [7:0] delay, // busy cycles per operation
	output logic fl_ack // one-cycle done pulse
);
	logic [7:0] cnt_r;
	int n_ops;
	logic [31:0] op_addr;
	logic [15:0] op_data;
	logic op_erase;
	logic op_seq;
	// Fields logged at the ack edge, while the request still holds them
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 8'h00;
			fl_ack <= 1'b0;
			n_ops <= 0;
		end else if (fl_ack) begin
			fl_ack <= 1'b0;
			cnt_r <= 8'h00;
			n_ops <= n_ops + 1;
			op_addr <= fl_addr;
			op_data <= fl_data;
			op_erase <= fl_erase;
			op_seq <= fl_seq;
		end else if (fl_req) begin
			if (cnt_r == delay) begin
				fl_ack <= 1'b1;
			end else begin
				cnt_r <= cnt_r + 8'h01;
			end
		end
	end
endmodule // fwc_flash_model

// *** bench/fwc_flash_ctrl_test.sv ***
/*
 * Self-checking bench for the flash write/erase controller.
 * Assumes the flash array model above and hready looped back from hreadyout.
 */
`timescale 1ns/1ps
module fwc_flash_ctrl_test;
	logic clock, rst_n, hsel, hwrite, hready, mon_enabled, fl_ack;
	logic fl_req, fl_erase, fl_seq, hreadyout, hresp;
	logic prefetch_inhibit, data_prefetch_enable, read_store_enable, read_timing_mode;
	logic [1:0] htrans, speed_mode_select;
	logic [31:0] haddr, hwdata, hrdata, fl_addr, rd_v;
	logic [15:0] fl_data;
	logic [7:0] delay;
	int errors, n_tests, cyc, stalls, n0;
	assign hready = hreadyout;
	fwc_flash_ctrl i_dut (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mon_enabled(mon_enabled),
		.fl_req(fl_req), .fl_erase(fl_erase), .fl_seq(fl_seq), .fl_addr(fl_addr),
		.fl_data(fl_data), .fl_ack(fl_ack), .prefetch_inhibit(prefetch_inhibit),
		.data_prefetch_enable(data_prefetch_enable), .read_store_enable(read_store_enable),
		.speed_mode_select(speed_mode_select), .read_timing_mode(read_timing_mode));
	fwc_flash_model i_fl (.clock(clock), .rst_n(rst_n), .fl_req(fl_req),
		.fl_erase(fl_erase), .fl_seq(fl_seq), .fl_addr(fl_addr), .fl_data(fl_data),
		.delay(delay), .fl_ack(fl_ack));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Cut a hang short well above the few hundred cycles the run needs
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			final_report();
		end
	end
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= 1'b1;
		haddr <= a;
		@(posedge clock);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		#1;
		while (!hreadyout && n < 300) begin
			@(posedge clock);
			#1;
			n++;
		end
		stalls = n;
		@(posedge clock);
		#1;
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= 1'b0;
		haddr <= a;
		@(posedge clock);
		hsel <= 1'b0;
		htrans <= 2'h0;
		#1;
		d = hrdata;
	endtask
	task automatic rc(input logic [31:0] a, input logic [31:0] exp, input string nm);
		logic [31:0] v;
		rd(a, v);
		chk(nm, v, exp);
	endtask
	// Settles long enough that a stray extra operation would show
	task automatic wait_ops(input int n);
		int k;
		k = 0;
		while (i_fl.n_ops < n && k < 500) begin
			@(posedge clock);
			k++;
		end
		repeat (25) @(posedge clock);
		chk("op_count", 32'(i_fl.n_ops), 32'(n));
	endtask
	task automatic keys(input logic [7:0] k1, input logic [7:0] k2);
		wr(fwc_pkg::KEY_ADDR, {24'h0, k1});
		wr(fwc_pkg::KEY_ADDR, {24'h0, k2});
	endtask
	task automatic do_reset;
		rst_n <= 1'b0;
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		repeat (5) @(posedge clock);
		n0 = i_fl.n_ops;
	endtask
	task automatic t_regs;
		rc(fwc_pkg::CFG_ADDR, fwc_pkg::CFG_RESET, "cfg_reset");
		rc(fwc_pkg::TCTL_ADDR, fwc_pkg::TCTL_RESET, "tctl_reset");
		rc(fwc_pkg::KEY_ADDR, 32'h0, "key_reset");
		chk("hresp", 32'(hresp), 32'h0);
		wr(fwc_pkg::CFG_ADDR, 32'hFFFFFFFF);
		rc(fwc_pkg::CFG_ADDR, fwc_pkg::CFG_WMASK, "cfg_ro_bits");
		wr(fwc_pkg::TCTL_ADDR, 32'hFFFFFFFF);
		rc(fwc_pkg::TCTL_ADDR, (fwc_pkg::TCTL_RESET & ~fwc_pkg::TCTL_WMASK)
			| fwc_pkg::TCTL_WMASK, "tctl_ro_bits");
		wr(fwc_pkg::DATA_ADDR, 32'h0);
		rc(fwc_pkg::DATA_ADDR, 32'h0, "wdata_wo");
		wr(32'h4002E0F0, 32'hFFFFFFFF);
		rc(32'h4002E0F0, 32'h0, "unmapped");
		wr(fwc_pkg::TADDR_ADDR, 32'hA5C3_0F0E);
		rc(fwc_pkg::TADDR_ADDR, 32'hA5C3_0F0E, "taddr_rw");
		chk("ops_locked", 32'(i_fl.n_ops), 32'(n0));
		$display("test regs finished");
	endtask
	task automatic t_cfg;
		for (int m = 0; m < 4; m++) begin
			wr(fwc_pkg::CFG_ADDR, fwc_pkg::CFG_RESET | 32'(m));
			rc(fwc_pkg::CFG_ADDR, fwc_pkg::CFG_RESET | 32'(m), "cfg_spd");
			chk("spd_pin", 32'(speed_mode_select), 32'(m));
		end
		wr(fwc_pkg::CFG_ADDR + fwc_pkg::SET_OFS, 32'h000000D0);
		chk("pfi_set", 32'(prefetch_inhibit), 32'h1);
		chk("dpf_set", 32'(data_prefetch_enable), 32'h1);
		chk("rds_set", 32'(read_store_enable), 32'h1);
		wr(fwc_pkg::CFG_ADDR + fwc_pkg::CLR_OFS, 32'h00000051);
		rc(fwc_pkg::CFG_ADDR, fwc_pkg::CFG_RESET | 32'h82, "cfg_clr");
		chk("pfi_keep", 32'(prefetch_inhibit), 32'h1);
		chk("dpf_clr", 32'(data_prefetch_enable), 32'h0);
		chk("rds_clr", 32'(read_store_enable), 32'h0);
		chk("spd_clr", 32'(speed_mode_select), 32'h2);
		wr(fwc_pkg::TCTL_ADDR, fwc_pkg::TCTL_RESET & ~32'h00000040);
		chk("rtm_low", 32'(read_timing_mode), 32'h0);
		wr(fwc_pkg::TCTL_ADDR, fwc_pkg::TCTL_RESET);
		chk("rtm_high", 32'(read_timing_mode), 32'h1);
		$display("test cfg finished");
	endtask
	task automatic t_single(input logic er, input logic [31:0] a);
		logic [31:0] c;
		c = fwc_pkg::CFG_RESET | {13'h0, er, 18'h0};
		wr(fwc_pkg::CFG_ADDR, c);
		wr(fwc_pkg::TADDR_ADDR, a);
		keys(fwc_pkg::KEY_INITIAL, fwc_pkg::KEY_SINGLE_UNLOCK);
		wr(fwc_pkg::DATA_ADDR, 32'hBEEF1234);
		rd(fwc_pkg::CFG_ADDR, rd_v);
		chk("busy", 32'(rd_v[20]), 32'h1);
		chk("req", 32'(fl_req), 32'h1);
		rc(fwc_pkg::TADDR_ADDR, a + 32'h2, "taddr_inc");
		wait_ops(n0 + 1);
		chk("op_addr", i_fl.op_addr, a);
		chk("op_data", 32'(i_fl.op_data), 32'h1234);
		chk("op_erase", 32'(i_fl.op_erase), 32'(er));
		chk("op_seq_single", 32'(i_fl.op_seq), 32'h0);
		rc(fwc_pkg::CFG_ADDR, c, "idle");
		wr(fwc_pkg::DATA_ADDR, 32'h5555);
		wait_ops(n0 + 1);
		$display("test single finished");
	endtask
	task automatic t_multi;
		delay <= 8'd20;
		wr(fwc_pkg::CFG_ADDR, fwc_pkg::CFG_RESET | 32'h00010000);
		wr(fwc_pkg::TADDR_ADDR, 32'h00000200);
		keys(fwc_pkg::KEY_INITIAL, fwc_pkg::KEY_MULTI_UNLOCK);
		wr(fwc_pkg::DATA_ADDR, 32'h1111);
		wr(fwc_pkg::DATA_ADDR, 32'h2222);
		rd(fwc_pkg::CFG_ADDR, rd_v);
		chk("buf_full", 32'(rd_v[19]), 32'h1);
		wr(fwc_pkg::DATA_ADDR, 32'h3333);
		chk("stalled", 32'(stalls > 0), 32'h1);
		wait_ops(n0 + 3);
		chk("op_seq", 32'(i_fl.op_seq), 32'h1);
		chk("op_last", i_fl.op_addr, 32'h00000204);
		chk("op_last_d", 32'(i_fl.op_data), 32'h3333);
		rc(fwc_pkg::CFG_ADDR, fwc_pkg::CFG_RESET | 32'h00010000, "buf_empty");
		wr(fwc_pkg::KEY_ADDR, {24'h0, fwc_pkg::KEY_MULTI_LOCK});
		wr(fwc_pkg::DATA_ADDR, 32'h4444);
		wait_ops(n0 + 3);
		keys(fwc_pkg::KEY_INITIAL, fwc_pkg::KEY_MULTI_UNLOCK);
		wr(fwc_pkg::DATA_ADDR, 32'h6666);
		wait_ops(n0 + 3);
		delay <= 8'd10;
		$display("test multi finished");
	endtask
	task automatic t_badkey;
		keys(fwc_pkg::KEY_INITIAL, 8'h33);
		keys(fwc_pkg::KEY_INITIAL, fwc_pkg::KEY_SINGLE_UNLOCK);
		wr(fwc_pkg::DATA_ADDR, 32'h7777);
		wait_ops(n0);
		$display("test badkey finished");
	endtask
	task automatic t_mon;
		mon_enabled <= 1'b0;
		repeat (6) @(posedge clock);
		keys(fwc_pkg::KEY_INITIAL, fwc_pkg::KEY_SINGLE_UNLOCK);
		wr(fwc_pkg::DATA_ADDR, 32'h8888);
		wait_ops(n0);
		mon_enabled <= 1'b1;
		repeat (6) @(posedge clock);
		wr(fwc_pkg::DATA_ADDR, 32'h9999);
		wait_ops(n0 + 1);
		$display("test mon finished");
	endtask
	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		mon_enabled = 1'b1;
		delay = 8'd10;
		do_reset();
		t_regs();
		do_reset();
		t_cfg();
		do_reset();
		t_single(1'b0, 32'h00000100);
		do_reset();
		t_single(1'b1, 32'h00000C06);
		do_reset();
		t_multi();
		do_reset();
		t_badkey();
		do_reset();
		t_mon();
		final_report();
	end
endmodule // fwc_flash_ctrl_test
